/* File: hdl/oss_sequencer.sv */
// Purpose: Operating-state sequencer: wake-up, init, idle, sleep
// Assumes: One 100 MHz clock; ring oscillator and pins are sampled
// Notes on behaviour
// [R1] Wake-up enables crystal and band-gap
// [R2] After 4 ms: regulator on, reset out released
// [R3] Init clocks logic from crystal divided by two
// [R4] Init after sleep or reset may restore configuration
// [R5] Init starts PLL, idles on lock
// [R6] Host keeps serial clock at most 3 MHz
// [R7] Host avoids serial access during PLL lock
// [R8] Crystal select without sequencing returns idle to init
// [R9] Idle keeps PLL running, output gated
// [R10] Idle allows serial clock up to 20 MHz
// [R11] Idle keeps analogue transmit and receive off
// [R12] Host command from idle starts transmit or receive
// [R13] Delayed command waits in idle until time
// [R14] Sleep turns all regulators off
// [R15] Ring-oscillator sleep counter expiry wakes device
// [R16] Deep sleep leaves on select low or wake pin held for 500 us
// [R17] Sleep count loaded before sleep, expiry once
`default_nettype none
module oss_sequencer #(
	parameter int unsigned WAKE_CYCLES = oss_pkg::WAKE_CYCLES,
	parameter int unsigned DEEP_CYCLES = oss_pkg::DEEP_CYCLES,
	parameter int unsigned LOCK_CYCLES = oss_pkg::LOCK_CYCLES
) (
	input  wire logic        clk,               // System clock
	input  wire logic        reset,             // Synchronous, active high
	input  wire logic        cmd_tx,            // Host: start transmit
	input  wire logic        cmd_rx,            // Host: start receive
	input  wire logic        cmd_delayed,       // Command waits for time
	input  wire logic        delay_reached,     // Programmed time passed
	input  wire logic        op_done,           // Transmit/receive ended
	input  wire logic        cmd_sleep,         // Enter sleep
	input  wire logic        cmd_deep,          // Enter lowest power hold
	input  wire logic        restore_en,        // Reload from store
	input  wire logic        xtal_select,       // Crystal as clock source
	input  wire logic        seq_enable,        // Automatic sequencing
	input  wire logic [15:0] sleep_count,       // Sleep expiry value
	input  wire logic        ring_osc,          // Ring oscillator pin
	input  wire logic        serial_select_low_pin, // Chip select, low
	input  wire logic        wake_pin,          // Wake-up pin
	input  wire logic        pll_locked,        // System PLL lock flag
	output logic             xtal_en,           // Crystal oscillator on
	output logic             bandgap_en,        // Band-gap on
	output logic             dig_reg_en,        // Digital regulator on
	output logic             reset_out_low,     // Reset output, low
	output logic             xtal_half_clock,   // Crystal clock / 2
	output logic             pll_en,            // System PLL on
	output logic             pll_gate,          // PLL output to logic
	output logic             use_pll_clock,     // Logic from PLL clock
	output logic             analog_en,         // TX/RX analogue power
	output logic             restore_pulse,     // Reload configuration
	output logic             serial_fast_ok,    // 20 MHz allowed
	output logic             sleep_expired,     // Sleep counter expiry
	output logic [2:0]       state_out          // Present state
);
	oss_pkg::oss_state_e state;
	oss_pkg::oss_state_e next_state;
	logic [oss_pkg::CNT_W-1:0] timer;
	logic [15:0] sleep_cnt;
	logic from_low_power;
	logic [1:0] ro_sync;
	logic [1:0] cs_sync;
	logic [1:0] wk_sync;
	logic [1:0] lk_sync;
	logic ro_prev;
	logic ro_rise;
	logic deep_wake;
	logic lock_seen;

	// Two-stage synchronisers for pin inputs
	always_ff @(posedge clk) begin
		ro_sync <= {ro_sync[0], ring_osc};
		cs_sync <= {cs_sync[0], serial_select_low_pin};
		wk_sync <= {wk_sync[0], wake_pin};
		lk_sync <= {lk_sync[0], pll_locked};
		ro_prev <= ro_sync[1];
	end

	assign ro_rise   = ro_sync[1] & ~ro_prev;
	assign deep_wake = ~cs_sync[1] | wk_sync[1];
	assign lock_seen = lk_sync[1] || (timer >= LOCK_CYCLES);

	// Next-state decode
	always_comb begin
		next_state = state;
		unique case (state)
			oss_pkg::ST_WAKEUP:
				if (timer >= WAKE_CYCLES - 1)
					next_state = oss_pkg::ST_INIT; // [R2]
			oss_pkg::ST_INIT:
				if (seq_enable && lock_seen)
					next_state = oss_pkg::ST_IDLE; // [R5]
			oss_pkg::ST_IDLE: begin
				if (xtal_select && !seq_enable) begin
					next_state = oss_pkg::ST_INIT; // [R8]
				end else if ((cmd_tx || cmd_rx) &&
					(!cmd_delayed || delay_reached)) begin
					next_state = cmd_tx ? oss_pkg::ST_TX
						: oss_pkg::ST_RX; // [R12] [R13]
				end else if (cmd_deep) begin
					next_state = oss_pkg::ST_DEEP;
				end else if (cmd_sleep) begin
					next_state = oss_pkg::ST_SLEEP;
				end
			end
			oss_pkg::ST_TX, oss_pkg::ST_RX:
				if (op_done)
					next_state = oss_pkg::ST_IDLE;
			oss_pkg::ST_SLEEP:
				if (ro_rise && sleep_cnt == 16'h0001)
					next_state = oss_pkg::ST_WAKEUP; // [R15]
			oss_pkg::ST_DEEP:
				if (deep_wake && timer >= DEEP_CYCLES - 1)
					next_state = oss_pkg::ST_WAKEUP; // [R16]
			default:
				next_state = oss_pkg::ST_WAKEUP;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset)
			state <= oss_pkg::ST_WAKEUP;
		else
			state <= next_state;
	end

	// Phase timer; in deep sleep counts wake condition duration
	always_ff @(posedge clk) begin
		if (reset || next_state != state)
			timer <= '0;
		else if (state == oss_pkg::ST_DEEP && !deep_wake)
			timer <= '0; // [R16]
		else if (timer != '1)
			timer <= timer + 1'b1;
	end

	// Sleep counter: loaded on entry, counts ring edges
	always_ff @(posedge clk) begin
		if (reset) begin
			sleep_cnt     <= oss_pkg::SLEEP_RESET;
			sleep_expired <= 1'b0;
		end else begin
			sleep_expired <= 1'b0;
			if (next_state == oss_pkg::ST_SLEEP &&
				state != oss_pkg::ST_SLEEP) begin
				sleep_cnt <= (sleep_count == 16'h0000) ? 16'h0001
					: sleep_count; // [R17]
			end else if (state == oss_pkg::ST_SLEEP && ro_rise &&
				sleep_cnt != 16'h0000) begin
				sleep_cnt <= sleep_cnt - 1'b1; // [R15]
				if (sleep_cnt == 16'h0001)
					sleep_expired <= 1'b1; // [R17]
			end
		end
	end

	// Low-power origin remembered for configuration restore
	always_ff @(posedge clk) begin
		if (reset)
			from_low_power <= 1'b1;
		else if (state == oss_pkg::ST_SLEEP ||
			state == oss_pkg::ST_DEEP)
			from_low_power <= 1'b1;
		else if (state == oss_pkg::ST_IDLE)
			from_low_power <= 1'b0;
	end

	// Restore pulse on entering init from wake-up
	always_ff @(posedge clk) begin
		if (reset)
			restore_pulse <= 1'b0;
		else
			restore_pulse <= restore_en && from_low_power &&
				next_state == oss_pkg::ST_INIT &&
				state == oss_pkg::ST_WAKEUP; // [R4]
	end

	// Crystal divide by two while in init
	always_ff @(posedge clk) begin
		if (reset || state != oss_pkg::ST_INIT)
			xtal_half_clock <= 1'b0;
		else
			xtal_half_clock <= ~xtal_half_clock; // [R3]
	end

	// Power and clock controls from next state
	always_ff @(posedge clk) begin
		if (reset) begin
			xtal_en        <= 1'b0;
			bandgap_en     <= 1'b0;
			dig_reg_en     <= 1'b0;
			reset_out_low  <= 1'b0;
			pll_en         <= 1'b0;
			pll_gate       <= 1'b0;
			use_pll_clock  <= 1'b0;
			analog_en      <= 1'b0;
			serial_fast_ok <= 1'b0;
		end else begin
			xtal_en       <= next_state != oss_pkg::ST_SLEEP &&
				next_state != oss_pkg::ST_DEEP; // [R1] [R14]
			bandgap_en    <= next_state != oss_pkg::ST_SLEEP &&
				next_state != oss_pkg::ST_DEEP; // [R1] [R14]
			dig_reg_en    <= next_state != oss_pkg::ST_WAKEUP &&
				next_state != oss_pkg::ST_SLEEP &&
				next_state != oss_pkg::ST_DEEP; // [R2] [R14]
			reset_out_low <= next_state != oss_pkg::ST_WAKEUP &&
				next_state != oss_pkg::ST_SLEEP &&
				next_state != oss_pkg::ST_DEEP; // [R2]
			pll_en        <= next_state == oss_pkg::ST_INIT ||
				next_state == oss_pkg::ST_IDLE ||
				next_state == oss_pkg::ST_TX ||
				next_state == oss_pkg::ST_RX; // [R5] [R9]
			pll_gate      <= next_state == oss_pkg::ST_TX ||
				next_state == oss_pkg::ST_RX; // [R9]
			use_pll_clock <= next_state == oss_pkg::ST_IDLE ||
				next_state == oss_pkg::ST_TX ||
				next_state == oss_pkg::ST_RX; // [R3]
			analog_en     <= next_state == oss_pkg::ST_TX ||
				next_state == oss_pkg::ST_RX; // [R11]
			serial_fast_ok <= next_state == oss_pkg::ST_IDLE; // [R10]
		end
	end

	assign state_out = state;

	// Assertions share the system clock and reset
	default clocking cb_seq @(posedge clk);
	endclocking
	default disable iff (reset);

	// Wake-up directly followed by init
	sequence s_wake_to_init;
		state == oss_pkg::ST_WAKEUP ##1 state == oss_pkg::ST_INIT;
	endsequence

	// Init held for two cycles
	sequence s_init_held;
		state == oss_pkg::ST_INIT ##1 state == oss_pkg::ST_INIT;
	endsequence

	// Idle directly followed by sleep
	sequence s_sleep_entry;
		state == oss_pkg::ST_IDLE ##1 state == oss_pkg::ST_SLEEP;
	endsequence

	// Wake-up power and reset output
	a_wake_power: assert property ( // [R1]
		!$past(reset) && state == oss_pkg::ST_WAKEUP
		|-> xtal_en && bandgap_en && !reset_out_low)
		else $error("wake-up power controls wrong");
	a_wake_release: assert property ( // [R2]
		s_wake_to_init |-> reset_out_low && dig_reg_en)
		else $error("reset not released on init entry");
	// Init runs on the divided crystal clock
	a_half_clock: assert property ( // [R3]
		state == oss_pkg::ST_INIT && $past(state) == oss_pkg::ST_INIT
		|-> xtal_half_clock != $past(xtal_half_clock))
		else $error("half clock stalled");
	a_init_xtal_clock: assert property ( // [R3]
		state == oss_pkg::ST_INIT |-> !use_pll_clock && pll_en)
		else $error("init not on crystal clock");
	a_restore_entry: assert property ( // [R4]
		restore_pulse |-> state == oss_pkg::ST_INIT &&
		$past(state) == oss_pkg::ST_WAKEUP)
		else $error("restore outside init entry");
	a_init_to_idle: assert property ( // [R5]
		state == oss_pkg::ST_INIT && seq_enable && lk_sync[1]
		|=> state == oss_pkg::ST_IDLE)
		else $error("no idle after lock");
	a_back_to_init: assert property ( // [R8]
		state == oss_pkg::ST_IDLE && xtal_select && !seq_enable
		|=> s_init_held)
		else $error("idle did not return to init");
	// Idle: clock running but gated, analogue off
	a_idle_clock: assert property ( // [R9]
		state == oss_pkg::ST_IDLE
		|-> pll_en && use_pll_clock && !pll_gate)
		else $error("idle clock controls wrong");
	a_fast_idle_only: assert property ( // [R10]
		serial_fast_ok == (state == oss_pkg::ST_IDLE))
		else $error("fast serial flag wrong");
	a_idle_analog_off: assert property ( // [R11]
		$past(state) == oss_pkg::ST_IDLE && state == oss_pkg::ST_IDLE
		|-> !analog_en && !pll_gate && pll_en)
		else $error("idle analogue or gate wrong");
	// Host commands from idle
	a_cmd_start: assert property ( // [R12]
		state == oss_pkg::ST_IDLE && cmd_tx && !cmd_delayed &&
		seq_enable |=> state == oss_pkg::ST_TX)
		else $error("transmit command not taken");
	a_delay_hold: assert property ( // [R13]
		state == oss_pkg::ST_IDLE && cmd_delayed && !delay_reached
		|=> state != oss_pkg::ST_TX && state != oss_pkg::ST_RX)
		else $error("delayed command started early");
	// Low-power states and their exits
	a_sleep_regs_off: assert property ( // [R14]
		state == oss_pkg::ST_SLEEP && $past(state) == oss_pkg::ST_SLEEP
		|-> !dig_reg_en && !xtal_en && !bandgap_en)
		else $error("regulator on in sleep");
	a_sleep_expiry: assert property ( // [R15]
		sleep_expired |-> state == oss_pkg::ST_WAKEUP)
		else $error("expiry without wake-up");
	a_deep_hold: assert property ( // [R16]
		state == oss_pkg::ST_DEEP && !deep_wake
		|=> state == oss_pkg::ST_DEEP)
		else $error("deep sleep left without wake");
	a_sleep_load: assert property ( // [R17]
		s_sleep_entry |-> sleep_cnt != 16'h0000)
		else $error("sleep count not loaded");
	a_expiry_once: assert property ( // [R17]
		sleep_expired |=> !sleep_expired)
		else $error("expiry flagged twice");
endmodule
`default_nettype wire

/* File: hdl/oss_pkg.sv */
// Purpose: Shared constants for the operating-state sequencer
// Assumes: 100 MHz system clock
// Notes:   Times are given in their own unit, cycles derived here
`default_nettype none
package oss_pkg;
	localparam int unsigned CLK_MHZ        = 100;
	localparam int unsigned WAKE_TIME_US   = 4000;
	localparam int unsigned WAKE_CYCLES    = WAKE_TIME_US * CLK_MHZ;
	localparam int unsigned LOCK_TIME_US   = 5;
	localparam int unsigned LOCK_CYCLES    = LOCK_TIME_US * CLK_MHZ;
	localparam int unsigned DEEP_TIME_US   = 500;
	localparam int unsigned DEEP_CYCLES    = DEEP_TIME_US * CLK_MHZ;
	localparam int unsigned XTAL_DIV       = 2;
	localparam int unsigned CNT_W          = 32;
	localparam int unsigned SLEEP_W        = 16;
	localparam logic [15:0] SLEEP_RESET    = 16'h0000;

	typedef enum logic [2:0] {
		ST_WAKEUP = 3'b000,
		ST_INIT   = 3'b001,
		ST_IDLE   = 3'b010,
		ST_TX     = 3'b011,
		ST_RX     = 3'b100,
		ST_SLEEP  = 3'b101,
		ST_DEEP   = 3'b110
	} oss_state_e;
endpackage
`default_nettype wire

/* File: bench/oss_host_model.sv */
// Purpose: Host side: select and wake pins, ring oscillator
// Assumes: Bench asks for a wake-up through wake_req
// Notes:   Ring oscillator runs only while the device sleeps
`default_nettype none
module oss_host_model (
	input  wire logic       clk,      // System clock
	input  wire logic [1:0] wake_req, // Bit 0 select, bit 1 wake pin
	input  wire logic [2:0] state,    // Device state
	output logic            cs_low,   // Chip select, low
	output logic            wake,     // Wake-up pin
	output logic            ring      // Ring oscillator
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div = 2'h0;
	// Select low only on wake_req bit 0: no serial access, none across lock
	assign cs_low = !wake_req[0];
	assign wake   = wake_req[1];
	// Slow ring oscillator, stopped outside sleep
	always @(posedge clk) begin
		div <= (state == 3'h5) ? div + 2'h1 : 2'h0;
	end
	assign ring = div[1];
endmodule
`default_nettype wire

/* File: bench/tb_oss_sequencer.sv */
// Purpose: Self-checking bench for the operating-state sequencer
// Assumes: Shortened wake, deep-sleep and lock counts
// Notes:   Inputs change on the falling edge
`default_nettype none
module tb_oss_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WK = 20;
	localparam int DP = 10;
	localparam int LK = 8;
	logic        clk = 1'h0;
	logic        reset = 1'h1;
	logic        cmd_tx, cmd_rx, cmd_delayed, delay_reached, op_done;
	logic        cmd_sleep, cmd_deep, restore_en, xtal_select;
	logic        seq_enable, pll_locked, cs_low, wake, ring;
	logic [15:0] sleep_count;
	logic [1:0]  wake_req;
	logic        xtal_en, bandgap_en, dig_reg_en, reset_out_low;
	logic        xtal_half_clock, pll_en, pll_gate, use_pll_clock;
	logic        analog_en, restore_pulse, serial_fast_ok, sleep_expired;
	logic [2:0]  state_out;
	logic        half_q;
	int          err_total = 0;
	int          comparisons = 0;
	int          n_rst = 0;
	int          n_exp = 0;
	int          n_tog = 0;

	oss_sequencer #(.WAKE_CYCLES(WK), .DEEP_CYCLES(DP), .LOCK_CYCLES(LK))
	i_oss_sequencer (.clk, .reset, .cmd_tx, .cmd_rx, .cmd_delayed,
		.delay_reached, .op_done, .cmd_sleep, .cmd_deep, .restore_en,
		.xtal_select, .seq_enable, .sleep_count, .ring_osc(ring),
		.serial_select_low_pin(cs_low), .wake_pin(wake), .pll_locked,
		.xtal_en, .bandgap_en, .dig_reg_en, .reset_out_low,
		.xtal_half_clock, .pll_en, .pll_gate, .use_pll_clock, .analog_en,
		.restore_pulse, .serial_fast_ok, .sleep_expired, .state_out);
	oss_host_model i_oss_host_model (.clk, .wake_req, .state(state_out),
		.cs_low, .wake, .ring);

	always #5 clk = ~clk;
	// Count one-cycle pulses and divided-clock edges, settled values
	always @(negedge clk) begin
		if (!reset) begin
			if (restore_pulse === 1'h1) n_rst++;
			if (sleep_expired === 1'h1) n_exp++;
			if (xtal_half_clock !== half_q) n_tog++;
		end
		half_q = xtal_half_clock;
	end

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wait_st(input logic [2:0] s, input int lim, output int n);
		n = 0;
		while (state_out !== s) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				check("timeout", 1'h1, 1'h0);
				print_verdict();
			end
		end
	endtask

	task automatic t_boot();
		int n;
		repeat (20) @(negedge clk);
		reset = 1'h0;
		@(negedge clk);
		check("xtal_en", xtal_en, 1'h1);
		check("bandgap_en", bandgap_en, 1'h1);
		check("reset_out_low", reset_out_low, 1'h0);
		wait_st(3'h1, WK + 4, n);
		check("wake_time", n >= WK - 2, 1'h1);
		check("dig_reg_en", dig_reg_en, 1'h1);
		check("reset_out_low", reset_out_low, 1'h1);
		check("pll_en", pll_en, 1'h1);
		check("xtal_clock", use_pll_clock, 1'h0);
		wait_st(3'h2, LK + 4, n);
		check("lock_time", n >= LK - 2, 1'h1);
		check("half_clock", n_tog >= LK, 1'h1);
		check("restore", n_rst, 1);
		check("pll_en", pll_en, 1'h1);
		check("pll_clock", use_pll_clock, 1'h1);
		check("pll_gate", pll_gate, 1'h0);
		check("fast_ok", serial_fast_ok, 1'h1);
		check("analog_en", analog_en, 1'h0);
	endtask
	task automatic t_cmd(input logic tx, input logic rx, input logic dly,
		input logic [2:0] s);
		int n;
		{cmd_tx, cmd_rx, cmd_delayed} = {tx, rx, dly};
		repeat (10) @(negedge clk);
		if (dly)
			check("held_idle", state_out, 3'h2);
		delay_reached = 1'h1;
		wait_st(s, 4, n);
		check("op_state", state_out, s);
		check("op_gate", pll_gate, 1'h1);
		check("op_analog", analog_en, 1'h1);
		check("op_fast_ok", serial_fast_ok, 1'h0);
		{cmd_tx, cmd_rx, cmd_delayed, delay_reached} = 4'h0;
		op_done = 1'h1;
		wait_st(3'h2, 4, n);
		op_done = 1'h0;
		@(negedge clk);
	endtask
	task automatic t_xtal();
		int n;
		{xtal_select, seq_enable} = 2'h2;
		wait_st(3'h1, 4, n);
		repeat (LK + 4) @(negedge clk);
		check("stay_init", state_out, 3'h1);
		check("init_clock", use_pll_clock, 1'h0);
		check("init_slow", serial_fast_ok, 1'h0);
		{xtal_select, seq_enable, pll_locked} = 3'h3;
		wait_st(3'h2, LK + 6, n);
	endtask
	task automatic t_sleep();
		int n;
		sleep_count = 16'h0003;
		cmd_sleep = 1'h1;
		wait_st(3'h5, 4, n);
		cmd_sleep = 1'h0;
		check("regulator", dig_reg_en, 1'h0);
		wait_st(3'h0, 40, n);
		check("sleep_len", n >= 8, 1'h1);
		check("xtal_wake", xtal_en, 1'h1);
		wait_st(3'h1, WK + 4, n);
		wait_st(3'h2, 4, n);
		check("lock_pin", n < LK, 1'h1);
		check("expiry_once", n_exp, 1);
		check("restore", n_rst, 2);
	endtask
	task automatic t_deep();
		int n;
		cmd_deep = 1'h1;
		wait_st(3'h6, 4, n);
		cmd_deep = 1'h0;
		wake_req = 2'h1;
		repeat (DP / 2) @(negedge clk);
		wake_req = 2'h0;
		repeat (DP + 4) @(negedge clk);
		check("deep_hold", state_out, 3'h6);
		wake_req = 2'h2;
		wait_st(3'h0, DP + 6, n);
		check("deep_len", n >= DP, 1'h1);
		wake_req = 2'h0;
		wait_st(3'h2, WK + LK + 8, n);
		check("restore", n_rst, 3);
	endtask

	// Main sequence
	initial begin
		{cmd_tx, cmd_rx, cmd_delayed, delay_reached, op_done} = 5'h00;
		{cmd_sleep, cmd_deep, xtal_select, pll_locked} = 4'h0;
		{restore_en, seq_enable} = 2'h3;
		sleep_count = 16'h0000;
		wake_req = 2'h0;
		t_boot();
		t_cmd(1'h1, 1'h0, 1'h0, 3'h3);
		t_cmd(1'h0, 1'h1, 1'h0, 3'h4);
		t_cmd(1'h1, 1'h1, 1'h0, 3'h3);
		t_cmd(1'h0, 1'h1, 1'h1, 3'h4);
		t_xtal();
		t_sleep();
		t_deep();
		print_verdict();
	end
endmodule
`default_nettype wire
